/* File: core/pmr_power_reset.sv */
`timescale 1ns/10ps
module pmr_power_reset
  import pmr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire pmr_sfr_req_t  sfr_req,
  output logic [7:0]         sfr_rdata,
  input  wire logic          supply_above_threshold,
  input  wire logic          power_on_delay_done,
  input  wire logic          flash_write_attempt,
  input  wire logic          irq_pending,
  output logic               cpu_clk_en,
  output logic               periph_clk_en,
  output logic               osc_run,
  output logic               core_reset,
  output logic               irq_timer_disable,
  output logic               sp_reinit,
  output logic               ram_write_block,
  output logic               port_force,
  output logic [7:0]         port_latch_value,
  output logic               port_open_drain,
  output logic               weak_pullup_en,
  output logic               rst_pin_out,
  output logic               rst_pin_oe,
  output logic               reset_exit,
  output logic [15:0]        fetch_addr,
  output logic               clk_sel_internal,
  output logic               wdt_tick,
  output logic               regulator_cal,
  output logic               monitor_enable,
  output logic               monitor_threshold_high
);

  logic [1:0] rst_sync;
  logic       rst_n_int;
  pmr_state_t s;
  pmr_state_t next_s;
  logic       in_reset;
  logic       mon_trip;
  logic       flash_err;
  logic       wr_power_mode;
  logic       wr_supply_mon;
  logic       wr_reset_cause;
  logic       rd_power_mode;
  logic       rd_supply_mon;
  logic       rd_reset_cause;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync[1];

  always_comb begin
    wr_power_mode  = 1'b0;
    wr_supply_mon  = 1'b0;
    wr_reset_cause = 1'b0;
    if (sfr_req.wr && (s.mode == ST_RUN)) begin
      if (sfr_req.addr == PMR_ADDR_POWER_MODE) begin
        wr_power_mode = 1'b1;
      end else if (sfr_req.addr == PMR_ADDR_SUPPLY_MON) begin
        wr_supply_mon = 1'b1;
      end else if (sfr_req.addr == PMR_ADDR_RESET_CAUSE) begin
        wr_reset_cause = 1'b1;
      end
    end
  end

  always_comb begin
    rd_power_mode  = 1'b0;
    rd_supply_mon  = 1'b0;
    rd_reset_cause = 1'b0;
    if (sfr_req.rd) begin
      if (sfr_req.addr == PMR_ADDR_POWER_MODE) begin
        rd_power_mode = 1'b1;
      end else if (sfr_req.addr == PMR_ADDR_SUPPLY_MON) begin
        rd_supply_mon = 1'b1;
      end else if (sfr_req.addr == PMR_ADDR_RESET_CAUSE) begin
        rd_reset_cause = 1'b1;
      end
    end
  end

  assign in_reset  = (s.mode == ST_POR_HOLD) || (s.mode == ST_SUPPLY_HOLD)
                     || (s.mode == ST_PULSE_HOLD);
  assign mon_trip  = s.supply_monitor_enable && s.monitor_source && !s.sup_ok;
  assign flash_err = flash_write_attempt
                     && !(s.supply_monitor_enable && s.supply_monitor_threshold_select);

  always_comb begin
    next_s = s;
    next_s.exit_pulse = 1'b0;
    next_s.sup_sync   = {s.sup_sync[1:0], supply_above_threshold};
    next_s.delay_sync = {s.delay_sync[1:0], power_on_delay_done};
    if (s.sup_sync[1] == s.sup_sync[2]) begin
      next_s.sup_ok = s.sup_sync[2];
    end
    if (s.delay_sync[1] == s.delay_sync[2]) begin
      next_s.delay_ok = s.delay_sync[2];
    end
    next_s.wdt_tick = (s.wdt_cnt == WDT_DIV_LAST);
    if (s.wdt_cnt == WDT_DIV_LAST) begin
      next_s.wdt_cnt = 4'h0;
    end else begin
      next_s.wdt_cnt = s.wdt_cnt + 4'h1;
    end

    if (rd_power_mode) begin
      next_s.rdata = {s.software_flags, 2'b00};
    end else if (rd_supply_mon) begin
      next_s.rdata = 8'h00;
      next_s.rdata[SMC_ENABLE_BIT] = s.supply_monitor_enable;
      next_s.rdata[SMC_STATUS_BIT] = s.sup_ok;
      next_s.rdata[SMC_LEVEL_BIT]  = s.supply_monitor_threshold_select;
    end else if (rd_reset_cause) begin
      next_s.rdata = 8'h00;
      next_s.rdata[RC_POWER_UP_BIT] = s.power_up_cause_flag;
      next_s.rdata[RC_SOFT_BIT]     = s.soft_flag;
      next_s.rdata[RC_FLASH_BIT]    = s.flash_flag;
    end else if (sfr_req.rd) begin
      next_s.rdata = 8'h00;
    end

    if (wr_power_mode) begin
      next_s.software_flags = sfr_req.wdata[7:PMC_FLAGS_LSB];
    end
    if (wr_supply_mon) begin
      next_s.supply_monitor_enable           = sfr_req.wdata[SMC_ENABLE_BIT];
      next_s.supply_monitor_threshold_select = sfr_req.wdata[SMC_LEVEL_BIT];
    end
    if (wr_reset_cause) begin
      next_s.monitor_source = sfr_req.wdata[RC_POWER_UP_BIT];
    end

    case (s.mode)
      ST_POR_HOLD: begin
        if (s.delay_ok && s.sup_ok) begin
          next_s.mode                = ST_RUN;
          next_s.exit_pulse          = 1'b1;
          next_s.power_up_cause_flag = 1'b1;
          next_s.soft_flag           = 1'b0;
          next_s.flash_flag          = 1'b0;
        end
      end
      ST_SUPPLY_HOLD: begin
        if (!mon_trip) begin
          next_s.mode                = ST_RUN;
          next_s.exit_pulse          = 1'b1;
          next_s.power_up_cause_flag = 1'b0;
          next_s.soft_flag           = 1'b0;
          next_s.flash_flag          = 1'b0;
        end
      end
      ST_PULSE_HOLD: begin
        if (mon_trip) begin
          next_s.mode  = ST_SUPPLY_HOLD;
          next_s.cause = CAUSE_SUPPLY;
        end else if (s.pulse_cnt == 5'h00) begin
          next_s.mode                = ST_RUN;
          next_s.exit_pulse          = 1'b1;
          next_s.power_up_cause_flag = 1'b0;
          next_s.soft_flag           = (s.cause == CAUSE_SOFT);
          next_s.flash_flag          = (s.cause == CAUSE_FLASH);
        end else begin
          next_s.pulse_cnt = s.pulse_cnt - 5'h01;
        end
      end
      ST_RUN: begin
        if (wr_power_mode && sfr_req.wdata[PMC_STOP_BIT]) begin
          next_s.mode = ST_STOP;
        end else if (wr_power_mode && sfr_req.wdata[PMC_IDLE_BIT]) begin
          next_s.mode = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_pending) begin
          next_s.mode = ST_RUN;
        end
      end
      ST_STOP: begin
        next_s.mode = ST_STOP;
      end
      default: begin
        next_s.mode = ST_POR_HOLD;
      end
    endcase

    if (!in_reset) begin
      if (mon_trip) begin
        next_s.mode  = ST_SUPPLY_HOLD;
        next_s.cause = CAUSE_SUPPLY;
      end else if (flash_err && (s.mode == ST_RUN)) begin
        next_s.mode      = ST_PULSE_HOLD;
        next_s.cause     = CAUSE_FLASH;
        next_s.pulse_cnt = RESET_PULSE_LOAD;
      end else if (wr_reset_cause && sfr_req.wdata[RC_SOFT_BIT]) begin
        next_s.mode      = ST_PULSE_HOLD;
        next_s.cause     = CAUSE_SOFT;
        next_s.pulse_cnt = RESET_PULSE_LOAD;
      end
      if (mon_trip || (flash_err && (s.mode == ST_RUN))
          || (wr_reset_cause && sfr_req.wdata[RC_SOFT_BIT])) begin
        next_s.software_flags = SW_FLAGS_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s <= '0;
      s.mode                            <= ST_POR_HOLD;
      s.cause                           <= CAUSE_POWER_ON;
      s.software_flags                  <= PMC_RESET[7:PMC_FLAGS_LSB];
      s.supply_monitor_enable           <= MON_ENABLE_POR;
      s.supply_monitor_threshold_select <= MON_HIGH_POR;
      s.monitor_source                  <= MON_SOURCE_POR;
    end else begin
      s <= next_s;
    end
  end

  assign sfr_rdata              = s.rdata;
  assign cpu_clk_en             = (s.mode == ST_RUN);
  assign periph_clk_en          = (s.mode == ST_RUN) || (s.mode == ST_IDLE);
  assign osc_run                = (s.mode != ST_STOP);
  assign core_reset             = in_reset;
  assign irq_timer_disable      = in_reset;
  assign sp_reinit              = in_reset;
  assign ram_write_block        = in_reset;
  assign port_force             = in_reset;
  assign port_latch_value       = PORT_LATCH_RESET;
  assign port_open_drain        = in_reset;
  assign weak_pullup_en         = 1'b1;
  assign rst_pin_out            = 1'b0;
  assign rst_pin_oe             = (s.mode == ST_POR_HOLD) || (s.mode == ST_SUPPLY_HOLD);
  assign reset_exit             = s.exit_pulse;
  assign fetch_addr             = FETCH_START_ADDR;
  assign clk_sel_internal       = in_reset || s.exit_pulse;
  assign wdt_tick               = s.wdt_tick && (s.mode != ST_STOP) && !in_reset;
  assign regulator_cal          = s.exit_pulse;
  assign monitor_enable         = s.supply_monitor_enable;
  assign monitor_threshold_high = s.supply_monitor_threshold_select;

endmodule

/* File: inc/pmr_pkg.sv */
package pmr_pkg;

  // Register addresses on the special-register port.
  localparam logic [7:0] PMR_ADDR_POWER_MODE  = 8'h87;
  localparam logic [7:0] PMR_ADDR_SUPPLY_MON  = 8'hFF;
  localparam logic [7:0] PMR_ADDR_RESET_CAUSE = 8'hEF;

  // Field positions of the power mode control register.
  localparam int PMC_IDLE_BIT  = 0;
  localparam int PMC_STOP_BIT  = 1;
  localparam int PMC_FLAGS_LSB = 2;

  // Field positions of the supply monitor control register.
  localparam int SMC_ENABLE_BIT = 7;
  localparam int SMC_STATUS_BIT = 6;
  localparam int SMC_LEVEL_BIT  = 5;

  // Field positions of the reset cause register.
  localparam int RC_POWER_UP_BIT = 1;
  localparam int RC_SOFT_BIT     = 4;
  localparam int RC_FLASH_BIT    = 6;

  // Reset values.
  localparam logic [7:0] PMC_RESET         = 8'h00;
  localparam logic [5:0] SW_FLAGS_RESET    = 6'h00;
  localparam logic       MON_ENABLE_POR    = 1'b1;
  localparam logic       MON_HIGH_POR      = 1'b0;
  localparam logic       MON_SOURCE_POR    = 1'b1;
  localparam logic [7:0] PORT_LATCH_RESET  = 8'hFF;
  localparam logic [15:0] FETCH_START_ADDR = 16'h0000;

  // Timing.
  localparam int CLK_PERIOD_NS      = 5;
  localparam int RESET_PULSE_NS     = 100;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_PULSE_LOAD = 5'(RESET_PULSE_CYCLES - 1);
  localparam int WDT_CLOCK_DIV      = 12;
  localparam logic [3:0] WDT_DIV_LAST = 4'(WDT_CLOCK_DIV - 1);

  typedef enum logic [5:0] {
    ST_POR_HOLD    = 6'h01,
    ST_SUPPLY_HOLD = 6'h02,
    ST_PULSE_HOLD  = 6'h04,
    ST_RUN         = 6'h08,
    ST_IDLE        = 6'h10,
    ST_STOP        = 6'h20
  } pmr_mode_t;

  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'h0,
    CAUSE_SUPPLY   = 2'h1,
    CAUSE_FLASH    = 2'h2,
    CAUSE_SOFT     = 2'h3
  } pmr_cause_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmr_sfr_req_t;

  typedef struct packed {
    pmr_mode_t  mode;
    pmr_cause_t cause;
    logic [4:0] pulse_cnt;
    logic [3:0] wdt_cnt;
    logic       wdt_tick;
    logic [5:0] software_flags;
    logic       supply_monitor_enable;
    logic       supply_monitor_threshold_select;
    logic       monitor_source;
    logic       power_up_cause_flag;
    logic       soft_flag;
    logic       flash_flag;
    logic [2:0] sup_sync;
    logic       sup_ok;
    logic [2:0] delay_sync;
    logic       delay_ok;
    logic [7:0] rdata;
    logic       exit_pulse;
  } pmr_state_t;

endpackage

/* File: dv/pmr_power_reset_chk.sv */
`timescale 1ns/10ps
module pmr_power_reset_chk
  import pmr_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset_n,
  input wire pmr_sfr_req_t sfr_req,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         flash_write_attempt,
  input wire logic         irq_pending,
  input wire logic         cpu_clk_en,
  input wire logic         periph_clk_en,
  input wire logic         osc_run,
  input wire logic         core_reset,
  input wire logic         port_force,
  input wire logic [7:0]   port_latch_value,
  input wire logic         rst_pin_out,
  input wire logic         rst_pin_oe,
  input wire logic         reset_exit,
  input wire logic         wdt_tick,
  input wire logic         monitor_enable,
  input wire logic         monitor_threshold_high
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  mode_read_zero_a: assert property (
    sfr_req.rd && sfr_req.addr == 8'h87 |=> sfr_rdata[1:0] == 2'h0) else $error("mode bits read set");
  reset_state_a: assert property (
    core_reset |-> port_force && port_latch_value == 8'hFF && !cpu_clk_en) else $error("reset state");
  pin_drive_a: assert property (
    rst_pin_oe |-> core_reset && !rst_pin_out) else $error("pin drive outside reset");
  exit_pulse_a: assert property (
    $fell(core_reset) |-> reset_exit ##1 !reset_exit) else $error("exit pulse wrong");
  idle_gate_a: assert property (
    cpu_clk_en |-> periph_clk_en && osc_run) else $error("clock enables inconsistent");
  stop_halt_a: assert property (
    !osc_run |-> !periph_clk_en && !wdt_tick ##1 (!osc_run || core_reset)) else $error("stop left");
  idle_wake_a: assert property (
    periph_clk_en && !cpu_clk_en && irq_pending |=> cpu_clk_en || core_reset) else $error("no wake");
  wdt_gap_a: assert property (
    wdt_tick |=> !wdt_tick [*8]) else $error("watchdog tick too soon");
  flash_trip_a: assert property (
    flash_write_attempt && cpu_clk_en && !(monitor_enable && monitor_threshold_high)
    |=> core_reset [*8]) else $error("flash error reset missing");
  exit_cov: cover property (reset_exit);
  wake_cov: cover property (periph_clk_en && !cpu_clk_en && irq_pending);
  flash_cov: cover property (flash_write_attempt && cpu_clk_en && !monitor_enable);
endmodule
bind pmr_power_reset pmr_power_reset_chk u_chk (
  .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .flash_write_attempt(flash_write_attempt), .irq_pending(irq_pending),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
  .core_reset(core_reset), .port_force(port_force), .port_latch_value(port_latch_value),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .reset_exit(reset_exit),
  .wdt_tick(wdt_tick), .monitor_enable(monitor_enable),
  .monitor_threshold_high(monitor_threshold_high)
);

/* File: dv/pmr_power_reset_bench.sv */
`timescale 1ns/10ps
module pmr_power_reset_bench;
  import pmr_pkg::*;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  pmr_sfr_req_t sfr_req = '0;
  logic         supply_ok = 1'b1;
  logic         delay_done = 1'b1;
  logic         flash_try = 1'b0;
  logic         irq = 1'b0;
  logic [7:0]   rdata;
  logic         cpu_en, per_en, osc, core_rst, pin_oe, exit_p;
  logic [7:0]   d;
  int           mismatches = 0;
  int           tests_run = 0;
  int           cycles = 0;
  int unsigned  seed;

  pmr_power_reset DUT (
    .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(rdata),
    .supply_above_threshold(supply_ok), .power_on_delay_done(delay_done),
    .flash_write_attempt(flash_try), .irq_pending(irq), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .osc_run(osc), .core_reset(core_rst), .irq_timer_disable(),
    .sp_reinit(), .ram_write_block(), .port_force(), .port_latch_value(),
    .port_open_drain(), .weak_pullup_en(), .rst_pin_out(), .rst_pin_oe(pin_oe),
    .reset_exit(exit_p), .fetch_addr(), .clk_sel_internal(), .wdt_tick(),
    .regulator_cal(), .monitor_enable(), .monitor_threshold_high()
  );

  always #2.5 clk = ~clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    sfr_req.wr <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    sfr_req.rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(what, exp, rdata);
  endtask

  task automatic wait_exit;
    int n;
    n = 0;
    while (exit_p !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("reset exit", 8'h01, exit_p);
  endtask

  task automatic flash;
    @(posedge clk);
    flash_try <= 1'b1;
    @(posedge clk);
    flash_try <= 1'b0;
    #1;
  endtask

  initial begin
    seed = $urandom(32'h08ED);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    wait_exit();
    rd("power up cause", 8'hEF, 8'h02);
    rd("monitor after power on", 8'hFF, 8'hC0);
    rd("power mode reset", 8'h87, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom()) & 8'hFC;
      if (i == 0) begin
        d = 8'hFC;
      end
      wr(8'h87, d);
      rd("software flags", 8'h87, d);
    end
    wr(8'h87, d | 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("idle cpu clock", 8'h00, cpu_en);
    chk("idle periph clock", 8'h01, per_en);
    rd("idle mode bits", 8'h87, d);
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle wake", 8'h01, cpu_en);
    wr(8'hFF, 8'h00);
    wr(8'hEF, 8'h10);
    wait_exit();
    rd("soft cause", 8'hEF, 8'h10);
    rd("monitor kept off", 8'hFF, 8'h40);
    rd("flags cleared", 8'h87, 8'h00);
    flash();
    chk("flash trip", 8'h01, core_rst);
    chk("flash pin idle", 8'h00, pin_oe);
    wait_exit();
    rd("flash cause", 8'hEF, 8'h40);
    wr(8'hFF, 8'hA0);
    flash();
    chk("flash guarded", 8'h00, core_rst);
    wr(8'hEF, 8'h02);
    @(posedge clk);
    supply_ok <= 1'b0;
    delay_done <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("supply hold", 8'h01, core_rst);
    chk("supply pin", 8'h01, pin_oe);
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_exit();
    rd("supply cause", 8'hEF, 8'h00);
    rd("monitor kept on", 8'hFF, 8'hE0);
    wr(8'h87, 8'h03);
    @(posedge clk);
    irq <= 1'b1;
    delay_done <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("stop oscillator", 8'h00, osc);
    chk("stop held", 8'h00, cpu_en);
    @(posedge clk);
    irq <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wait_exit();
    rd("monitor power on", 8'hFF, 8'hC0);
    rd("power up again", 8'hEF, 8'h02);
    test_done();
  end
endmodule
